// ---- hw/remap_cache_tagger.sv ----
// Tagged translation cache store: context, PASID, TLB, paging-structure
// and interrupt-entry caches share one entry array, told apart by kind.
// Assumes the driver presents one request at a time on the link.
`timescale 1ns/1ps
`default_nettype none
`include "remap_cache_regs.svh"
module remap_cache_tagger #(
	parameter int        ENTRIES          = 8,
	parameter logic      ALLOW_SHARED_HIT = 1'b1
) (
	input  wire logic                clk_in,
	input  wire logic                rst_in,
	remap_cache_if.device            link,
	output logic [ENTRIES-1:0]       valid_map_out
);
	localparam int PW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

	typedef struct packed {
		logic                           valid;
		remap_cache_pkg::cache_kind_type kind;
		logic                           untagged;
		logic                           second_level;
		logic [1:0]                     size_level;
		logic [15:0]                    sid;
		logic [19:0]                    pasid;
		logic [15:0]                    domain_tag;
		logic [63:0]                    tag;
	} entry_type;

	typedef struct packed {
		entry_type [ENTRIES-1:0]   ent;
		logic [PW-1:0]             victim;
		logic                      resp_valid;
		remap_cache_pkg::resp_type resp;
	} state_type;

	state_type cur;
	state_type next_cur;

	// Keep address bits lo..hi, clear the rest
	function automatic logic [63:0] span(input logic [63:0] a,
		input logic [5:0] hi, input logic [5:0] lo);
		logic [63:0] m;
		m = '0;
		for (int i = 0; i < 64; i++)
		begin
			m[i] = a[i] && (i <= int'(hi)) && (i >= int'(lo));
		end
		return m;
	endfunction

	function automatic logic [5:0] low_bit(
		input remap_cache_pkg::cache_kind_type k, input logic [1:0] sl);
		logic [5:0] r;
		r = 6'h00;
		if (k == remap_cache_pkg::KIND_PSC)
		begin
			case (sl)
				2'h0: r = `PSC_LOW_LVL2;
				2'h1: r = `PSC_LOW_LVL3;
				2'h2: r = `PSC_LOW_LVL4;
				default: r = `PSC_LOW_LVL5;
			endcase
		end
		else
		begin
			case (sl)
				2'h0: r = `PAGE_LOW_4K;
				2'h1: r = `PAGE_LOW_2M;
				default: r = `PAGE_LOW_1G;
			endcase
		end
		return r;
	endfunction

	function automatic logic [5:0] top_bit(
		input remap_cache_pkg::cache_kind_type k, input logic second,
		input remap_cache_pkg::cfg_type c);
		logic [5:0] r;
		if (second)
			r = c.max_guest_addr_width;
		else if (k == remap_cache_pkg::KIND_PSC)
			r = `PSC_FL_TOP;
		else
			r = c.five_level ? `TOP_FIVE_LEVEL : `TOP_FOUR_LEVEL;
		return r;
	endfunction

	// Address tag of a request, shaped by the entry's own size
	function automatic logic [63:0] addr_key(input entry_type e,
		input logic [63:0] a, input remap_cache_pkg::cfg_type c);
		logic [63:0] r;
		if (e.kind == remap_cache_pkg::KIND_IRQ)
			r = span(a, `IRQ_KEY_TOP, 6'h00);
		else
			r = span(a, top_bit(e.kind, e.second_level, c),
				low_bit(e.kind, e.size_level));
		return r;
	endfunction

	function automatic logic hit_of(input entry_type e,
		input remap_cache_pkg::request_type r, input logic [19:0] pid,
		input remap_cache_pkg::cfg_type c);
		logic h;
		logic tag_eq;
		tag_eq = (e.tag == addr_key(e, r.addr, c));
		h = 1'b0;
		if (e.valid && e.kind == r.kind)
		begin
			case (e.kind)
				remap_cache_pkg::KIND_CTX: h = (e.sid == r.sid);
				remap_cache_pkg::KIND_PASID:
					h = (c.root_table_mode_select == `TTM_SCALABLE)
						&& e.pasid == pid && e.sid == r.sid;
				remap_cache_pkg::KIND_TLB:
				begin
					h = tag_eq && e.sid == r.sid;
					if (r.has_pasid)
						h = h && ((!e.untagged && e.pasid == pid)
							|| (ALLOW_SHARED_HIT && e.untagged));
					else
						h = h && e.untagged;
				end
				remap_cache_pkg::KIND_PSC:
					h = tag_eq && e.domain_tag == r.domain_tag
						&& (e.second_level || e.pasid == pid);
				remap_cache_pkg::KIND_IRQ: h = tag_eq;
				default: h = 1'b0;
			endcase
		end
		return h;
	endfunction

	function automatic logic inv_of(input entry_type e,
		input remap_cache_pkg::request_type r, input logic [19:0] pid,
		input remap_cache_pkg::cfg_type c);
		return e.valid && e.kind == r.kind
			&& (!r.sel.use_sid || e.sid == r.sid)
			&& (!r.sel.use_did || e.domain_tag == r.domain_tag)
			&& (!r.sel.use_pasid || e.pasid == pid)
			&& (!r.sel.use_addr || e.tag == addr_key(e, r.addr, c));
	endfunction

	always_comb
	begin
		remap_cache_pkg::request_type r;
		remap_cache_pkg::cfg_type     c;
		logic [19:0]                  pid;
		logic                         found;
		logic                         accept;
		logic                         spare;
		logic [PW-1:0]                slot;
		entry_type                    ne;
		r = link.req;
		c = link.cfg;
		pid = r.pasid;
		found = 1'b0;
		accept = 1'b1;
		spare = 1'b0;
		slot = cur.victim;
		ne = '0;
		next_cur = cur;
		next_cur.resp_valid = 1'b0;
		if (!r.has_pasid && c.root_table_mode_select == `TTM_SCALABLE)
		begin
			for (int i = 0; i < ENTRIES; i++)
			begin
				if (cur.ent[i].valid
					&& cur.ent[i].kind == remap_cache_pkg::KIND_CTX
					&& cur.ent[i].sid == r.sid)
					pid = cur.ent[i].pasid;
			end
		end
		if (link.req_valid)
		begin
			next_cur.resp_valid = 1'b1;
			next_cur.resp = '0;
			case (r.op)
				remap_cache_pkg::OP_LOOKUP:
				begin
					for (int i = 0; i < ENTRIES; i++)
					begin
						if (!found && hit_of(cur.ent[i], r, pid, c))
						begin
							found = 1'b1;
							next_cur.resp.hit = 1'b1;
							next_cur.resp.untagged = cur.ent[i].untagged;
							next_cur.resp.domain_tag = cur.ent[i].domain_tag;
							next_cur.resp.pasid = cur.ent[i].pasid;
						end
					end
				end
				remap_cache_pkg::OP_INV:
				begin
					for (int i = 0; i < ENTRIES; i++)
					begin
						if (inv_of(cur.ent[i], r, pid, c))
						begin
							next_cur.ent[i].valid = 1'b0;
							next_cur.resp.hit = 1'b1;
						end
					end
				end
				remap_cache_pkg::OP_FILL:
				begin
					ne.valid = 1'b1;
					ne.kind = r.kind;
					ne.second_level = r.second_level;
					ne.size_level = r.size_level;
					ne.sid = r.sid;
					ne.pasid = pid;
					ne.domain_tag = r.domain_tag;
					ne.untagged = !r.has_pasid;
					ne.tag = addr_key(ne, r.addr, c);
					if (r.fault && !c.cache_faults_capability
						&& (r.kind == remap_cache_pkg::KIND_CTX
						|| r.kind == remap_cache_pkg::KIND_PASID))
						accept = 1'b0;
					if (r.kind == remap_cache_pkg::KIND_PASID
						&& c.root_table_mode_select != `TTM_SCALABLE)
						accept = 1'b0;
					if (r.kind == remap_cache_pkg::KIND_CTX && r.fault
						&& !r.ctx_present)
						ne.domain_tag = `RESERVED_DOMAIN;
					// A refill of the same key overwrites in place
					for (int i = 0; i < ENTRIES; i++)
					begin
						if (!found && hit_of(cur.ent[i], r, pid, c))
						begin
							found = 1'b1;
							slot = PW'(i);
						end
					end
					for (int i = ENTRIES - 1; i >= 0; i--)
					begin
						if (!found && !cur.ent[i].valid)
						begin
							spare = 1'b1;
							slot = PW'(i);
						end
					end
					if (!found && !spare
						&& r.kind == remap_cache_pkg::KIND_PASID
						&& cur.ent[slot].kind == remap_cache_pkg::KIND_PASID
						&& cur.ent[slot].pasid == pid)
						slot = PW'((int'(slot) + 1) % ENTRIES);
					if (accept)
					begin
						next_cur.ent[slot] = ne;
						if (!found && !spare)
							next_cur.victim = PW'((int'(slot) + 1) % ENTRIES);
					end
					next_cur.resp.hit = accept;
					next_cur.resp.untagged = ne.untagged;
					next_cur.resp.domain_tag = ne.domain_tag;
					next_cur.resp.pasid = ne.pasid;
				end
				default:
					next_cur.resp_valid = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign link.resp_valid = cur.resp_valid;
	assign link.resp = cur.resp;

	always_comb
	begin
		for (int i = 0; i < ENTRIES; i++)
		begin
			valid_map_out[i] = cur.ent[i].valid;
		end
	end
endmodule // remap_cache_tagger
`default_nettype wire

// ---- include/remap_cache_regs.svh ----
// Constants for the remapping cache tagging unit and its driver.
// Assumes inclusion by bare name from include/.
`ifndef REMAP_CACHE_REGS_SVH
`define REMAP_CACHE_REGS_SVH
`define PAGE_LOW_4K      6'h0c
`define PAGE_LOW_2M      6'h15
`define PAGE_LOW_1G      6'h1e
`define TOP_FIVE_LEVEL   6'h38
`define TOP_FOUR_LEVEL   6'h2f
`define PSC_FL_TOP       6'h38
`define PSC_LOW_LVL5     6'h30
`define PSC_LOW_LVL4     6'h27
`define PSC_LOW_LVL3     6'h1e
`define PSC_LOW_LVL2     6'h15
`define IRQ_KEY_TOP      6'h0f
`define TTM_SCALABLE     2'h1
`define RESERVED_DOMAIN  16'h0000
`define REG_CMD          12'h000
`define REG_ADDR_LO      12'h004
`define REG_ADDR_HI      12'h008
`define REG_TAGS         12'h00c
`define REG_PASID        12'h010
`define REG_CFG          12'h014
`define REG_ROOT         12'h018
`define REG_STATUS       12'h01c
`define REG_RESULT       12'h020
`endif

// ---- include/remap_cache_pkg.sv ----
// Types shared by the tagging unit, its driver and their interface.
// Assumes remap_cache_regs.svh for numeric constants.
package remap_cache_pkg;
	typedef enum logic [2:0] {
		KIND_CTX   = 3'h0,
		KIND_PASID = 3'h1,
		KIND_TLB   = 3'h2,
		KIND_PSC   = 3'h3,
		KIND_IRQ   = 3'h4
	} cache_kind_type;
	typedef enum logic [1:0] {
		OP_LOOKUP = 2'h0,
		OP_FILL   = 2'h1,
		OP_INV    = 2'h2
	} op_type;
	typedef struct packed {
		logic use_sid;
		logic use_did;
		logic use_pasid;
		logic use_addr;
	} inv_sel_type;
	// Size code 0/1/2 = 4K/2M/1G; level code 0..3 = level2..level5
	typedef struct packed {
		op_type         op;
		cache_kind_type kind;
		logic [63:0]    addr;
		logic [15:0]    sid;
		logic [19:0]    pasid;
		logic           has_pasid;
		logic [15:0]    domain_tag;
		logic [1:0]     size_level;
		logic           second_level;
		logic           fault;
		logic           ctx_present;
		inv_sel_type    sel;
	} request_type;
	typedef struct packed {
		logic       cache_faults_capability;
		logic [1:0] root_table_mode_select;
		logic       five_level;
		logic [5:0] max_guest_addr_width;
	} cfg_type;
	typedef struct packed {
		logic        hit;
		logic        untagged;
		logic [15:0] domain_tag;
		logic [19:0] pasid;
	} resp_type;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ISSUE = 3'b010,
		ST_WAIT  = 3'b100
	} drv_state_type;
endpackage

// ---- include/remap_cache_if.sv ----
// Link between the tagging unit and the driver that feeds it.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface remap_cache_if;
	logic                          req_valid;
	remap_cache_pkg::request_type  req;
	remap_cache_pkg::cfg_type      cfg;
	logic                          resp_valid;
	remap_cache_pkg::resp_type     resp;
	modport device (
		input  req_valid, req, cfg,
		output resp_valid, resp
	);
	modport driver (
		output req_valid, req, cfg,
		input  resp_valid, resp
	);
endinterface
`default_nettype wire

// ---- hw/remap_cache_driver.sv ----
// Software-facing driver: APB registers, ordered invalidation sequences
// and programming checks, feeding the tagging unit over the link.
// Assumes an APB master on the same clock as the link.
`timescale 1ns/1ps
`default_nettype none
`include "remap_cache_regs.svh"
module remap_cache_driver (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	remap_cache_if.driver    link
);
	typedef struct packed {
		remap_cache_pkg::drv_state_type st;
		logic [5:0]                     cmd;
		logic [63:0]                    addr;
		logic [31:0]                    tags;
		logic [31:0]                    pinfo;
		remap_cache_pkg::cfg_type       cfg;
		logic [31:0]                    root;
		logic                           last_valid;
		logic [15:0]                    last_did;
		logic [31:0]                    last_root;
		logic [1:0]                     step;
		logic                           hit;
		logic                           refused;
		logic                           untagged;
		logic [15:0]                    rdid;
		logic [19:0]                    rpasid;
		logic [31:0]                    prdata;
		logic                           pready;
		logic                           pslverr;
		logic                           req_valid;
		remap_cache_pkg::request_type   req;
	} state_type;

	state_type cur;
	state_type next_cur;

	// Kind for each step of an ordered invalidation; 3'h7 ends it
	function automatic logic [2:0] seq_kind(input logic pasid_seq,
		input logic [1:0] step, input logic scalable);
		logic [2:0] k;
		k = 3'h7;
		if (!pasid_seq)
		begin
			case (step)
				2'h0: k = remap_cache_pkg::KIND_CTX;
				2'h1: k = scalable ? remap_cache_pkg::KIND_PASID
					: remap_cache_pkg::KIND_TLB;
				2'h2: k = scalable ? remap_cache_pkg::KIND_TLB : 3'h7;
				default: k = 3'h7;
			endcase
		end
		else
		begin
			case (step)
				2'h0: k = remap_cache_pkg::KIND_PASID;
				2'h1: k = remap_cache_pkg::KIND_TLB;
				2'h2: k = remap_cache_pkg::KIND_PSC;
				default: k = 3'h7;
			endcase
		end
		return k;
	endfunction

	always_comb
	begin
		logic       scal;
		logic       acc;
		logic       done;
		logic [2:0] k;
		scal = (cur.cfg.root_table_mode_select == `TTM_SCALABLE);
		acc = psel_in && penable_in && !cur.pready;
		// Second access edge, the one that samples pready high
		done = psel_in && penable_in && cur.pready;
		k = seq_kind(cur.cmd[5], cur.step, scal);
		next_cur = cur;
		next_cur.pready = acc;
		next_cur.pslverr = 1'b0;
		next_cur.req_valid = 1'b0;
		if (acc)
		begin
			next_cur.prdata = '0;
			case (paddr_in)
				`REG_CMD: next_cur.prdata = {26'h0, cur.cmd};
				`REG_ADDR_LO: next_cur.prdata = cur.addr[31:0];
				`REG_ADDR_HI: next_cur.prdata = cur.addr[63:32];
				`REG_TAGS: next_cur.prdata = cur.tags;
				`REG_PASID: next_cur.prdata = cur.pinfo;
				`REG_CFG: next_cur.prdata = {22'h0, cur.cfg};
				`REG_ROOT: next_cur.prdata = cur.root;
				`REG_STATUS: next_cur.prdata = {cur.rdid, 12'h0,
					cur.untagged, cur.refused, cur.hit,
					cur.st != remap_cache_pkg::ST_IDLE};
				`REG_RESULT: next_cur.prdata = {12'h0, cur.rpasid};
				default: next_cur.pslverr = 1'b1;
			endcase
			// Status and result are read-only
			if (pwrite_in && (paddr_in == `REG_STATUS
				|| paddr_in == `REG_RESULT))
				next_cur.pslverr = 1'b1;
		end
		// Writes land only when the master sees pready high
		if (done && pwrite_in)
		begin
			case (paddr_in)
				`REG_ADDR_LO: next_cur.addr[31:0] = pwdata_in;
				`REG_ADDR_HI: next_cur.addr[63:32] = pwdata_in;
				`REG_TAGS: next_cur.tags = pwdata_in;
				`REG_PASID: next_cur.pinfo = pwdata_in;
				`REG_CFG: next_cur.cfg = pwdata_in[9:0];
				`REG_ROOT: next_cur.root = pwdata_in;
				`REG_CMD:
				begin
					// Commands while busy are dropped
					if (cur.st == remap_cache_pkg::ST_IDLE)
					begin
						next_cur.cmd = pwdata_in[5:0];
						next_cur.step = 2'h0;
						next_cur.refused = 1'b0;
						next_cur.hit = 1'b0;
						next_cur.st = remap_cache_pkg::ST_ISSUE;
					end
				end
				default: ;
			endcase
		end
		case (cur.st)
			remap_cache_pkg::ST_IDLE: ;
			remap_cache_pkg::ST_ISSUE:
			begin
				next_cur.req.addr = cur.addr;
				next_cur.req.sid = cur.tags[15:0];
				next_cur.req.domain_tag = cur.tags[31:16];
				next_cur.req.pasid = cur.pinfo[19:0];
				next_cur.req.has_pasid = cur.pinfo[20];
				next_cur.req.fault = cur.pinfo[21];
				next_cur.req.ctx_present = cur.pinfo[22];
				next_cur.req.second_level = cur.pinfo[23];
				next_cur.req.size_level = cur.pinfo[25:24];
				next_cur.req.sel = cur.pinfo[29:26];
				next_cur.req.op = remap_cache_pkg::op_type'(cur.cmd[4:3]);
				next_cur.req.kind =
					remap_cache_pkg::cache_kind_type'(cur.cmd[2:0]);
				if (cur.cmd[4:3] == 2'h3)
				begin
					next_cur.req.op = remap_cache_pkg::OP_INV;
					next_cur.req.kind = remap_cache_pkg::cache_kind_type'(k);
				end
				next_cur.req_valid = 1'b1;
				next_cur.st = remap_cache_pkg::ST_WAIT;
				if (cur.cmd[4:3] == 2'h1 && cur.cmd[2:0] == 3'h0
					&& !cur.pinfo[21])
				begin
					if ((cur.cfg.cache_faults_capability
						&& cur.tags[31:16] == `RESERVED_DOMAIN)
						|| (cur.last_valid && cur.last_did == cur.tags[31:16]
						&& cur.last_root != cur.root))
					begin
						next_cur.req_valid = 1'b0;
						next_cur.refused = 1'b1;
						next_cur.st = remap_cache_pkg::ST_IDLE;
					end
					else
					begin
						next_cur.last_valid = 1'b1;
						next_cur.last_did = cur.tags[31:16];
						next_cur.last_root = cur.root;
					end
				end
			end
			remap_cache_pkg::ST_WAIT:
			begin
				if (link.resp_valid)
				begin
					next_cur.hit = cur.hit | link.resp.hit;
					next_cur.untagged = link.resp.untagged;
					next_cur.rdid = link.resp.domain_tag;
					next_cur.rpasid = link.resp.pasid;
					next_cur.st = remap_cache_pkg::ST_IDLE;
					if (cur.cmd[4:3] == 2'h3 && seq_kind(cur.cmd[5],
						cur.step + 2'h1, scal) != 3'h7)
					begin
						next_cur.step = cur.step + 2'h1;
						next_cur.st = remap_cache_pkg::ST_ISSUE;
					end
				end
			end
			default: next_cur.st = remap_cache_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cur <= '0;
			cur.st <= remap_cache_pkg::ST_IDLE;
		end
		else
			cur <= next_cur;
	end

	assign prdata_out = cur.prdata;
	assign pready_out = cur.pready;
	assign pslverr_out = cur.pslverr;
	assign link.req_valid = cur.req_valid;
	assign link.req = cur.req;
	assign link.cfg = cur.cfg;
endmodule // remap_cache_driver
`default_nettype wire

// ---- verification/remap_cache_tagging_fill_props.sv ----
// Checker on the link between the tagging unit and its driver.
// Assumes one clock; takes the interface signals as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module remap_cache_tagging_fill_props (
	input wire logic                         clk_in,
	input wire logic                         rst_in,
	input wire logic                         req_valid,
	input wire remap_cache_pkg::request_type req,
	input wire remap_cache_pkg::cfg_type     cfg,
	input wire logic                         resp_valid,
	input wire remap_cache_pkg::resp_type    resp
);
	logic fill;
	logic cap;
	assign fill = req_valid && req.op == remap_cache_pkg::OP_FILL;
	assign cap = cfg.cache_faults_capability;
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	a_answer_next: assert property (
		req_valid && req.op != 2'h3 |=> resp_valid)
		else $error("no answer one cycle after request");
	a_answer_cause: assert property (
		resp_valid |-> $past(req_valid))
		else $error("answer without request");
	a_ctx_fault_out: assert property (
		fill && req.kind == 3'h0 && req.fault && !cap |=> !resp.hit)
		else $error("faulting context entry stored");
	a_pasid_fault_out: assert property (
		fill && req.kind == 3'h1 && req.fault && !cap |=> !resp.hit)
		else $error("faulting pasid entry stored");
	a_pasid_mode_only: assert property (
		req_valid && req.kind == 3'h1 && req.op != 2'h2 &&
		cfg.root_table_mode_select != 2'h1 |=> !resp.hit)
		else $error("pasid cache used outside scalable mode");
	a_untagged_flag: assert property (
		fill && req.kind == 3'h2
		|=> resp.untagged == !$past(req.has_pasid))
		else $error("tlb fill untagged flag wrong");
	a_tagged_pasid: assert property (
		fill && req.kind == 3'h2 && req.has_pasid
		|=> resp.pasid == $past(req.pasid))
		else $error("tlb fill pasid tag wrong");
	a_ctx_zero_domain: assert property (
		fill && req.kind == 3'h0 && req.fault && !req.ctx_present && cap
		|=> !resp.hit || resp.domain_tag == 16'h0000)
		else $error("faulting context entry not on domain zero");
	a_request_pulse: assert property (
		req_valid |=> !req_valid)
		else $error("next step issued before answer");
endmodule // remap_cache_tagging_fill_props
`default_nettype wire

// ---- verification/test_remap_cache_tagging_fill.sv ----
// Bench for the tagging unit and its APB driver joined over the link.
// Assumes both ends share clk_in; commands run one at a time.
`timescale 1ns/1ps
`default_nettype none
`include "remap_cache_regs.svh"
`define CHK(what, exp, got) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) \
		begin \
			failures++; \
			$display("mismatch %s expected %h seen %h", what, exp, got); \
		end \
	end
module test_remap_cache_tagging_fill;
	localparam logic [5:0]  FILL = 6'h08;
	localparam logic [5:0]  INV = 6'h10;
	localparam logic [5:0]  ORD = 6'h18;
	localparam logic [63:0] B = 64'h0001_0000_0000_0000;
	logic        clk_in;
	logic        rst_in;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  valid_map;
	logic [31:0] st;
	logic        err;
	logic [5:0]  c;
	logic [31:0] pw;
	logic [2:0]  kinds[$];
	int          lows[5] = '{12, 21, 30, 21, 48};
	logic [1:0]  szs[5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h3};
	int          failures;
	int          num_checks;
	remap_cache_if link_if();
	remap_cache_tagger u_remap_cache_tagger (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.link         (link_if),
		.valid_map_out(valid_map)
	);
	remap_cache_driver u_remap_cache_driver (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.paddr_in   (paddr),
		.psel_in    (psel),
		.penable_in (penable),
		.pwrite_in  (pwrite),
		.pwdata_in  (pwdata),
		.prdata_out (prdata),
		.pready_out (pready),
		.pslverr_out(pslverr),
		.link       (link_if)
	);
	remap_cache_tagging_fill_props u_props (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.req_valid (link_if.req_valid),
		.req       (link_if.req),
		.cfg       (link_if.cfg),
		.resp_valid(link_if.resp_valid),
		.resp      (link_if.resp)
	);
	always #10 clk_in = ~clk_in;
	// Kinds seen on the wire give the order of invalidation steps
	always @(posedge clk_in)
		if (link_if.req_valid === 1'b1)
			kinds.push_back(link_if.req.kind);
	task automatic give_verdict();
		if (failures == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic bound(input logic ok);
		if (!ok)
		begin
			failures++;
			give_verdict();
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		st = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		bound(pready === 1'b1);
	endtask
	// Loads the operands, issues one command and waits for idle
	task automatic t(input logic [5:0] cmd, input logic [63:0] a,
		input logic [31:0] tg, input logic [31:0] p, input logic h);
		int n;
		apb(1'b1, `REG_ADDR_LO, a[31:0]);
		apb(1'b1, `REG_ADDR_HI, a[63:32]);
		apb(1'b1, `REG_TAGS, tg);
		apb(1'b1, `REG_PASID, p);
		apb(1'b1, `REG_CMD, {26'h0, cmd});
		n = 0;
		do
		begin
			apb(1'b0, `REG_STATUS, 32'h0);
			n++;
		end
		while (st[0] !== 1'b0 && n < 20);
		bound(st[0] === 1'b0);
		if (cmd[4:3] != 2'h3)
			`CHK("hit", h, st[1])
	endtask
	initial
	begin
		clk_in = 1'b0;
		rst_in = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		failures = 0;
		num_checks = 0;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		`CHK("map", 8'h00, valid_map)
		apb(1'b0, 12'h024, 32'h0);
		`CHK("err", 1'b1, err)
		apb(1'b0, `REG_STATUS, 32'h0);
		`CHK("status", 32'h0, st)
		apb(1'b1, `REG_CFG, 32'h0f0);
		for (int i = 0; i < 5; i++)
		begin
			c = (i < 3) ? 6'h2 : 6'h3;
			pw = {6'h0, szs[i], 4'h1, 20'(i + 1)};
			t(FILL | c, B, 32'h0003_0001, pw, 1'b1);
			t(c, B + (64'h1 << lows[i]) - 64'h1, 32'h0003_0001, pw, 1'b1);
			t(c, B + (64'h1 << lows[i]), 32'h0003_0001, pw, 1'b0);
		end
		t(INV | 6'h2, 0, 32'h0003_0001, 32'h1000_0000, 1'b1);
		t(INV | 6'h2, 0, 32'h0003_0001, 32'h1000_0000, 1'b0);
		t(INV | 6'h3, 0, 32'h0003_0001, 32'h1000_0000, 1'b1);
		apb(1'b1, `REG_CFG, 32'h0b0);
		t(FILL | 6'h2, 64'h5000, 32'h1, 32'h0010_0014, 1'b1);
		t(6'h2, 64'h0004_0000_0000_5000, 32'h1, 32'h0010_0014, 1'b1);
		apb(1'b1, `REG_CFG, 32'h0f0);
		t(6'h2, 64'h0004_0000_0000_5000, 32'h1, 32'h0010_0014, 1'b0);
		apb(1'b1, `REG_CFG, 32'h0e6);
		t(FILL | 6'h2, 64'h5000, 32'h1, 32'h0090_0015, 1'b1);
		t(6'h2, 64'h0100_0000_5000, 32'h1, 32'h0090_0015, 1'b1);
		t(6'h2, 64'h0020_0000_5000, 32'h1, 32'h0090_0015, 1'b0);
		apb(1'b1, `REG_CFG, 32'h0f0);
		t(FILL, 0, 32'h0007_0002, 32'h0040_0009, 1'b1);
		t(6'h0, 0, 32'h0007_0002, 32'h0, 1'b1);
		t(6'h0, 0, 32'h0007_0003, 32'h0, 1'b0);
		t(FILL | 6'h2, 64'h9000, 32'h0007_0002, 32'h0, 1'b1);
		`CHK("untagged", 1'b1, st[3])
		apb(1'b0, `REG_RESULT, 32'h0);
		`CHK("pasid", 32'h9, st)
		t(6'h2, 64'h9000, 32'h0007_0002, 32'h0010_0009, 1'b1);
		t(6'h2, 64'h9000, 32'h0007_0003, 32'h0010_0009, 1'b0);
		t(FILL, 0, 32'h0008_0004, 32'h0060_0000, 1'b0);
		t(6'h0, 0, 32'h0008_0004, 32'h0, 1'b0);
		t(FILL | 6'h1, 0, 32'h0008_0004, 32'h0070_000b, 1'b0);
		t(FILL | 6'h4, 64'h123, 32'h0, 32'h0, 1'b1);
		t(6'h4, 64'h123, 32'h0, 32'h0, 1'b1);
		t(6'h4, 64'h124, 32'h0, 32'h0, 1'b0);
		kinds.delete();
		t(ORD, 0, 32'h0007_0002, 32'h0, 1'b0);
		`CHK("order", 9'b000_001_010, {kinds[0], kinds[1], kinds[2]})
		kinds.delete();
		t(ORD | 6'h20, 0, 32'h0007_0002, 32'h0, 1'b0);
		`CHK("order", 9'b001_010_011, {kinds[0], kinds[1], kinds[2]})
		apb(1'b1, `REG_CFG, 32'h070);
		t(FILL | 6'h1, 0, 32'h0008_0004, 32'h0050_000c, 1'b0);
		kinds.delete();
		t(ORD, 0, 32'h0007_0002, 32'h0, 1'b0);
		`CHK("order", 6'b000_010, {kinds[0], kinds[1]})
		apb(1'b1, `REG_CFG, 32'h2f0);
		t(FILL, 0, 32'h0005_0005, 32'h0020_0000, 1'b1);
		`CHK("domain", 16'h0000, st[31:16])
		t(FILL | 6'h1, 0, 32'h0006_0004, 32'h0070_000b, 1'b1);
		`CHK("domain", 16'h0006, st[31:16])
		apb(1'b0, `REG_RESULT, 32'h0);
		`CHK("pasid", 32'hb, st)
		t(FILL, 0, 32'h0000_0009, 32'h0040_0000, 1'b0);
		`CHK("refused", 1'b1, st[2])
		apb(1'b1, `REG_ROOT, 32'h1);
		t(FILL, 0, 32'h0007_000a, 32'h0040_0000, 1'b0);
		`CHK("refused", 1'b1, st[2])
		t(FILL, 0, 32'h000a_000a, 32'h0040_0000, 1'b1);
		`CHK("refused", 1'b0, st[2])
		give_verdict();
	end
endmodule // test_remap_cache_tagging_fill
`default_nettype wire
